/* File: logic/uarx_regs.vh */
// register map, field positions, reset values and timing for the uart receive block
//============================================================================
// Functional notes
// - a finished frame whose parity bit disagrees with the data parity sets the parity error flag.
// - a finished frame whose stop slot is low sets the framing error flag.
// - a frame finishing while the last byte is still unread sets the overrun error flag.
// - all error flags read zero while power or receive enable is off; a status read clears them.
// - the parity check follows the parity mode field of the operation mode register.
// - only the first stop bit is checked, whatever stop length is configured.
// - on overrun the new byte is dropped and the buffer keeps the older unread byte.
// - clock select values 0 to 10 give a base clock of the peripheral clock over 2 to that power.
// - clock select 11 takes the 8-bit timer output; other values are not to be written.
// - reset clears clock select to zero, the undivided peripheral clock.
// - every read of the error status register takes one extra wait cycle.
// - the timer source is the internal toggle, independent of the timer pin enable.
// - the error status register is read-only and its upper five bits read zero.
`ifndef UARX_REGS_VH
`define UARX_REGS_VH

//============================================================================
// register indexes (byte address is four times the index)
`define UARX_AW            18
`define UARX_IDX_OPMODE    16'hFF50
`define UARX_IDX_RXBUF     16'hFF52
`define UARX_IDX_ERRSTAT   16'hFF53
`define UARX_IDX_CLKSEL    16'hFF56
`define UARX_IDX_BAUDDIV   16'hFF57

//============================================================================
// operation mode fields
`define UARX_OM_POWER      7
`define UARX_OM_TXE        6
`define UARX_OM_RXE        5
`define UARX_OM_PAR_HI     4
`define UARX_OM_PAR_LO     3
`define UARX_OM_LEN8       2
`define UARX_OM_STOP2      1

//============================================================================
// error status fields
`define UARX_ES_PE         2
`define UARX_ES_FE         1
`define UARX_ES_OVE        0

//============================================================================
// parity modes
`define UARX_PAR_NONE      2'h0
`define UARX_PAR_ZERO      2'h1
`define UARX_PAR_ODD       2'h2
`define UARX_PAR_EVEN      2'h3

//============================================================================
// reset values and clock select codes
`define UARX_RST_OPMODE    8'h00
`define UARX_RST_CLKSEL    4'h0
`define UARX_RST_BAUDDIV   8'h10
`define UARX_CS_MAXDIV     4'hA
`define UARX_CS_TIMER      4'hB
`define UARX_PRESC_W       10

`endif

/* File: logic/uarx_presc.v */
// free-running prescaler producing the serial base clock enable
`default_nettype none
`include "uarx_regs.vh"

module uarx_presc #(
   parameter W = `UARX_PRESC_W
) (
   input  wire       sys_clk,
   input  wire       rst_n,
   input  wire       clk_en,
   input  wire [3:0] sel,
   input  wire       timer_toggle,
   output reg        tick_r
);

   reg  [W-1:0] cnt_r;
   reg          tog_prev_r;
   reg  [W-1:0] mask;
   reg          tick_nxt;

   //=========================================================================
   // tick selection
   always @* begin
      mask = {W{1'b0}};
      if (sel != 4'h0 && sel <= `UARX_CS_MAXDIV) begin
         mask = ~({W{1'b1}} << sel);
      end
      if (sel <= `UARX_CS_MAXDIV) begin
         tick_nxt = &(cnt_r | ~mask);
      end else if (sel == `UARX_CS_TIMER) begin
         tick_nxt = timer_toggle ^ tog_prev_r;
      end else begin
         tick_nxt = 1'b0; // prohibited codes simply stall the receiver
      end
   end

   //=========================================================================
   // counter runs free so a divisor change never has to restart it
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         cnt_r      <= {W{1'b0}};
         tog_prev_r <= 1'b0;
         tick_r     <= 1'b0;
      end else if (clk_en) begin
         cnt_r      <= cnt_r + {{(W-1){1'b0}}, 1'b1};
         tog_prev_r <= timer_toggle;
         tick_r     <= tick_nxt;
      end
   end

endmodule
`default_nettype wire

/* File: logic/uarx_top.v */
// uart receiver with error flags, base clock select and apb register slave
//
// The APB interface to the registers was decided locally.
`default_nettype none
`include "uarx_regs.vh"

module uarx_top #(
   parameter AW = `UARX_AW
) (
   input  wire          sys_clk,
   input  wire          rst_n,
   input  wire          clk_en,
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [AW-1:0] paddr,
   input  wire [31:0]   pwdata,
   input  wire [3:0]    pstrb,
   output reg  [31:0]   prdata,
   output reg           pready,
   output reg           pslverr,
   input  wire          rxd_pin,
   input  wire          timer_toggle,
   output reg           rx_frame_done_r
);

   //=========================================================================
   // state codes
   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_START = 3'h1;
   localparam [2:0] ST_DATA  = 3'h2;
   localparam [2:0] ST_PAR   = 3'h3;
   localparam [2:0] ST_STOP  = 3'h4;

   localparam [AW-1:0] A_OPMODE  = {`UARX_IDX_OPMODE, 2'b00};
   localparam [AW-1:0] A_RXBUF   = {`UARX_IDX_RXBUF, 2'b00};
   localparam [AW-1:0] A_ERRSTAT = {`UARX_IDX_ERRSTAT, 2'b00};
   localparam [AW-1:0] A_CLKSEL  = {`UARX_IDX_CLKSEL, 2'b00};
   localparam [AW-1:0] A_BAUDDIV = {`UARX_IDX_BAUDDIV, 2'b00};

   //=========================================================================
   // declarations
   reg  [7:0]  opmode_r;
   reg  [3:0]  clksel_r;
   reg  [7:0]  bauddiv_r;
   reg  [7:0]  rxbuf_r;
   reg         rxbuf_full_r;
   reg         pe_r;
   reg         fe_r;
   reg         ove_r;
   reg         wait_done_r;
   reg         rxd_s1_r;
   reg         rxd_s2_r;
   reg         rxd_prev_r;
   reg  [2:0]  state_r;
   reg  [7:0]  bcnt_r;
   reg  [2:0]  bit_r;
   reg  [7:0]  shift_r;
   reg         par_acc_r;
   reg         par_bit_r;

   wire        base_tick;
   wire        active;
   wire        acc;
   wire        done;
   wire        acc_first;
   wire        rd_stat;
   wire        rd_buf;
   wire        bit_evt;
   wire [1:0]  par_mode;
   wire        par_used;
   wire [2:0]  last_bit;
   wire        par_err;
   wire [7:0]  rx_data;
   wire        frame_end;

   reg         mapped;
   reg  [7:0]  rd_data;

   // next values of the flag and buffer registers
   reg         pe_nxt;
   reg         fe_nxt;
   reg         ove_nxt;
   reg  [7:0]  rxbuf_nxt;
   reg         rxbuf_full_nxt;

   //=========================================================================
   // base clock prescaler
   uarx_presc #(
      .W            (`UARX_PRESC_W)
   ) u_presc (
      .sys_clk      (sys_clk),
      .rst_n        (rst_n),
      .clk_en       (clk_en),
      .sel          (clksel_r),
      .timer_toggle (timer_toggle),
      .tick_r       (base_tick)
   );

   //=========================================================================
   // apb decode
   assign active   = opmode_r[`UARX_OM_POWER] & opmode_r[`UARX_OM_RXE];
   assign acc      = psel & penable;
   assign done     = acc & pready;
   assign acc_first = acc & ~pready;
   // status and buffer reads act at the edge that captures prdata, so a
   // frame ending during the read is never lost
   assign rd_stat  = acc_first & ~pwrite & (paddr == A_ERRSTAT) & wait_done_r;
   assign rd_buf   = acc_first & ~pwrite & (paddr == A_RXBUF);
   assign par_mode = {opmode_r[`UARX_OM_PAR_HI], opmode_r[`UARX_OM_PAR_LO]};
   assign par_used = (par_mode != `UARX_PAR_NONE);
   assign last_bit = opmode_r[`UARX_OM_LEN8] ? 3'h7 : 3'h6;

   always @* begin
      mapped  = 1'b1;
      rd_data = 8'h00;
      case (paddr)
         A_OPMODE:  rd_data = opmode_r;
         A_RXBUF:   rd_data = rxbuf_r;
         A_ERRSTAT: rd_data = {5'h00, pe_r, fe_r, ove_r};
         A_CLKSEL:  rd_data = {4'h0, clksel_r};
         A_BAUDDIV: rd_data = bauddiv_r;
         default:   mapped = 1'b0;
      endcase
   end

   //=========================================================================
   // apb handshake: answer one cycle into the access phase, two for status reads
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         pready      <= 1'b0;
         pslverr     <= 1'b0;
         prdata      <= 32'h0000_0000;
         wait_done_r <= 1'b0;
      end else if (clk_en) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         if (acc && !pready) begin
            if (!pwrite && paddr == A_ERRSTAT && !wait_done_r) begin
               wait_done_r <= 1'b1;
            end else begin
               wait_done_r <= 1'b0;
               pready      <= 1'b1;
               pslverr     <= ~mapped | (pwrite & (paddr == A_ERRSTAT | paddr == A_RXBUF));
               prdata      <= pwrite ? 32'h0000_0000 : {24'h000000, rd_data};
            end
         end
      end
   end

   //=========================================================================
   // software registers; writes land at the completing edge
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         opmode_r  <= `UARX_RST_OPMODE;
         clksel_r  <= `UARX_RST_CLKSEL;
         bauddiv_r <= `UARX_RST_BAUDDIV;
      end else if (clk_en && done && pwrite && pstrb[0]) begin
         if (paddr == A_OPMODE) begin
            opmode_r <= pwdata[7:0];
         end
         if (paddr == A_CLKSEL) begin
            clksel_r <= pwdata[3:0];
         end
         if (paddr == A_BAUDDIV) begin
            bauddiv_r <= pwdata[7:0];
         end
      end
   end

   //=========================================================================
   // serial input synchroniser
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         rxd_s1_r   <= 1'b1;
         rxd_s2_r   <= 1'b1;
         rxd_prev_r <= 1'b1;
      end else if (clk_en) begin
         rxd_s1_r   <= rxd_pin;
         rxd_s2_r   <= rxd_s1_r;
         rxd_prev_r <= rxd_s2_r;
      end
   end

   //=========================================================================
   // receive sequencer; bit period is bauddiv base ticks, sampled mid-bit
   assign bit_evt   = base_tick & (bcnt_r == 8'h00);
   assign frame_end = (state_r == ST_STOP) & bit_evt;
   assign rx_data   = opmode_r[`UARX_OM_LEN8] ? shift_r : {1'b0, shift_r[7:1]};
   assign par_err   = ((par_mode == `UARX_PAR_ODD) & ~(par_acc_r ^ par_bit_r))
                    | ((par_mode == `UARX_PAR_EVEN) & (par_acc_r ^ par_bit_r));

   always @(posedge sys_clk) begin
      if (!rst_n) begin
         state_r   <= ST_IDLE;
         bcnt_r    <= 8'h00;
         bit_r     <= 3'h0;
         shift_r   <= 8'h00;
         par_acc_r <= 1'b0;
         par_bit_r <= 1'b0;
      end else if (clk_en) begin
         if (base_tick) begin
            bcnt_r <= (bcnt_r == 8'h00) ? bauddiv_r - 8'h01 : bcnt_r - 8'h01;
         end
         if (!active) begin
            state_r <= ST_IDLE;
         end else begin
            case (state_r)
               ST_IDLE: begin
                  if (rxd_prev_r && !rxd_s2_r) begin
                     bcnt_r    <= {1'b0, bauddiv_r[7:1]};
                     bit_r     <= 3'h0;
                     par_acc_r <= 1'b0;
                     state_r   <= ST_START;
                  end
               end
               ST_START: begin
                  if (bit_evt) begin
                     state_r <= rxd_s2_r ? ST_IDLE : ST_DATA; // short glitches are dropped
                  end
               end
               ST_DATA: begin
                  if (bit_evt) begin
                     shift_r   <= {rxd_s2_r, shift_r[7:1]};
                     par_acc_r <= par_acc_r ^ rxd_s2_r;
                     bit_r     <= bit_r + 3'h1;
                     if (bit_r == last_bit) begin
                        state_r <= par_used ? ST_PAR : ST_STOP;
                     end
                  end
               end
               ST_PAR: begin
                  if (bit_evt) begin
                     par_bit_r <= rxd_s2_r;
                     state_r   <= ST_STOP;
                  end
               end
               ST_STOP: begin
                  if (bit_evt) begin
                     state_r <= ST_IDLE;
                  end
               end
               default: state_r <= ST_IDLE;
            endcase
         end
      end
   end

   //=========================================================================
   // flag and buffer next values; a new error beats a same-cycle clear
   always @* begin
      pe_nxt         = pe_r;
      fe_nxt         = fe_r;
      ove_nxt        = ove_r;
      rxbuf_nxt      = rxbuf_r;
      rxbuf_full_nxt = rxbuf_full_r;
      if (!active) begin
         pe_nxt         = 1'b0;
         fe_nxt         = 1'b0;
         ove_nxt        = 1'b0;
         rxbuf_full_nxt = 1'b0;
      end else begin
         if (rd_stat) begin
            pe_nxt  = 1'b0;
            fe_nxt  = 1'b0;
            ove_nxt = 1'b0;
         end
         if (rd_buf) begin
            rxbuf_full_nxt = 1'b0;
         end
         if (frame_end && par_err) begin
            pe_nxt = 1'b1;
         end
         if (frame_end && !rxd_s2_r) begin
            fe_nxt = 1'b1;
         end
         if (frame_end && rxbuf_full_r && !rd_buf) begin
            ove_nxt = 1'b1;
         end else if (frame_end) begin
            rxbuf_nxt      = rx_data;
            rxbuf_full_nxt = 1'b1;
         end
      end
   end

   //=========================================================================
   // receive buffer and error flag registers
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         rxbuf_r         <= 8'h00;
         rxbuf_full_r    <= 1'b0;
         pe_r            <= 1'b0;
         fe_r            <= 1'b0;
         ove_r           <= 1'b0;
         rx_frame_done_r <= 1'b0;
      end else if (clk_en) begin
         rx_frame_done_r <= frame_end & active; // no completion pulse once disabled
         pe_r            <= pe_nxt;
         fe_r            <= fe_nxt;
         ove_r           <= ove_nxt;
         rxbuf_r         <= rxbuf_nxt;
         rxbuf_full_r    <= rxbuf_full_nxt;
      end
   end

endmodule
`default_nettype wire

/* File: tb/uarx_monitor.sv */
// port checker for the uart receive block
`default_nettype none
`include "uarx_regs.vh"
module uarx_monitor #(
   parameter AW = `UARX_AW
) (
   input wire logic          sys_clk,
   input wire logic          rst_n,
   input wire logic          clk_en,
   input wire logic          psel,
   input wire logic          penable,
   input wire logic          pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0]   pwdata,
   input wire logic [3:0]    pstrb,
   input wire logic [31:0]   prdata,
   input wire logic          pready,
   input wire logic          pslverr,
   input wire logic          rxd_pin,
   input wire logic          timer_toggle,
   input wire logic          rx_frame_done_r
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [AW-1:0] AD_ES = `UARX_IDX_ERRSTAT * 4;
   localparam logic [AW-1:0] AD_CS = `UARX_IDX_CLKSEL * 4;
   localparam logic [AW-1:0] AD_OM = `UARX_IDX_OPMODE * 4;
   //==========
   // shadow state
   wire logic  acc = psel && penable;
   wire logic  esr = pready && !pwrite && paddr == AD_ES;
   wire logic  wok = acc && pready && pwrite && pstrb[0] && !pslverr;
   logic [3:0] cs_r;
   logic       on_r;
   logic       clean_r;
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         cs_r <= 4'h0;
         on_r <= 1'b0;
         clean_r <= 1'b1;
      end else begin
         if (wok && paddr == AD_CS) cs_r <= pwdata[3:0];
         if (wok && paddr == AD_OM) on_r <= pwdata[7] && pwdata[5];
         // a frame ending beats a clearing read
         if (rx_frame_done_r) clean_r <= 1'b0;
         else if (esr) clean_r <= 1'b1;
      end
   end
   //==========
   // assertions
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   property p_es_wait;
      $rose(acc) && !pwrite && paddr == AD_ES |-> !pready ##1 !pready ##1 pready;
   endproperty
   a_es_wait: assert property (p_es_wait) else $error("status wait wrong");
   property p_rg_wait;
      $rose(acc) && (pwrite || paddr != AD_ES) |-> !pready ##1 pready;
   endproperty
   a_rg_wait: assert property (p_rg_wait) else $error("access length wrong");
   property p_hi_zero;
      esr |-> prdata[31:3] == 29'h0;
   endproperty
   a_hi_zero: assert property (p_hi_zero) else $error("status upper bits set");
   property p_ro;
      pready && pwrite && paddr == AD_ES |-> pslverr;
   endproperty
   a_ro: assert property (p_ro) else $error("status write accepted");
   property p_cs_rd;
      pready && !pwrite && paddr == AD_CS |-> prdata == {28'h0, cs_r};
   endproperty
   a_cs_rd: assert property (p_cs_rd) else $error("clock select value wrong");
   property p_off;
      esr && !$past(on_r) |-> prdata[2:0] == 3'h0;
   endproperty
   a_off: assert property (p_off) else $error("flags while disabled");
   // a disable landing with the stop sample still lets that one frame complete
   property p_done_on;
      rx_frame_done_r |-> $past(on_r);
   endproperty
   a_done_on: assert property (p_done_on) else $error("frame while disabled");
   property p_clr;
      esr && clean_r |-> prdata[2:0] == 3'h0;
   endproperty
   a_clr: assert property (p_clr) else $error("flags not cleared by read");
   c_frame: cover property (rx_frame_done_r);
   c_err: cover property (esr && prdata[2:0] != 3'h0);
   c_tmr: cover property (wok && paddr == AD_CS && pwdata[3:0] == 4'hB);
endmodule
bind uarx_top uarx_monitor #(.AW(AW)) mon_u (.sys_clk(sys_clk), .rst_n(rst_n),
   .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .rxd_pin(rxd_pin), .timer_toggle(timer_toggle), .rx_frame_done_r(rx_frame_done_r));
`default_nettype wire

/* File: tb/uarx_remote.sv */
// remote serial node sending frames onto the receive line
`default_nettype none
module uarx_remote (
   input wire logic sys_clk,
   output var logic rxd
);
   timeunit 1ns;
   timeprecision 1ns;
   initial rxd = 1'b1;
   // always eleven slots; without parity the last slot is idle high
   task automatic send(input logic [7:0] d, input logic [1:0] pm, input logic bp,
                       input logic so, input int cyc);
      logic [10:0] f;
      logic        par;
      par = (pm == 2'h3 ? ^d : pm == 2'h2 ? ~^d : 1'b0) ^ bp;
      f = pm == 2'h0 ? {1'b1, so, d, 1'b0} : {so, par, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         rxd <= f[i];
         repeat (cyc) @(posedge sys_clk);
      end
      rxd <= 1'b1;
   endtask
endmodule
`default_nettype wire

/* File: tb/uart_rx_error_and_clock_select_tb.sv */
// self-checking bench for the uart receive block
`default_nettype none
`include "uarx_regs.vh"
module uart_rx_error_and_clock_select_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [17:0] AD_OM = `UARX_IDX_OPMODE * 4;
   localparam logic [17:0] AD_RB = `UARX_IDX_RXBUF * 4;
   localparam logic [17:0] AD_ES = `UARX_IDX_ERRSTAT * 4;
   localparam logic [17:0] AD_CS = `UARX_IDX_CLKSEL * 4;
   logic        sys_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        tmr = 1'b0;
   logic [17:0] paddr = 18'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, err, rxd, fdone;
   int          fail_count = 0;
   int          n_checks = 0;
   int          n_done = 0;
   int          seed = 32'h213C;
   int          cyc_t[3] = '{16, 32, 48};
   logic [3:0]  cs_t[3] = '{4'h0, 4'h1, 4'hB};
   uarx_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd_pin(rxd),
      .timer_toggle(tmr), .rx_frame_done_r(fdone));
   uarx_remote rem_u (.sys_clk(sys_clk), .rxd(rxd));
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   always begin
      repeat (3) @(posedge sys_clk);
      tmr <= ~tmr;
   end
   always @(posedge sys_clk) begin
      if (fdone === 1'b1) n_done++;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // idle cycle between transfers; waits for pready, then checks the wait length
   task automatic bus(input logic w, input logic [17:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         k++;
      end while (pready !== 1'b1);
      chk(k, (!w && a == AD_ES) ? 3 : 2);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic frame(input logic [7:0] d, input logic [1:0] pm, input logic bp,
                        input logic so, input int cyc, input int exp_n);
      int n0;
      n0 = n_done;
      rem_u.send(d, pm, bp, so, cyc);
      repeat (cyc) @(posedge sys_clk);
      chk(n_done - n0, exp_n);
   endtask
   function automatic logic [31:0] exp_es(logic [1:0] pm, logic bp, logic so, logic full);
      return {29'h0, bp && pm[1], !so, full};
   endfunction
   initial begin
      #200000;
      fail_count++;
      close_out();
   end
   initial begin
      logic [7:0] d;
      logic       so;
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      bus(0, AD_CS, 0);
      chk(rd, 32'h0);
      bus(0, AD_ES, 0);
      chk(rd, 32'h0);
      bus(0, AD_OM + 18'h4, 0);
      chk(err, 1);
      chk(rd, 32'h0);
      bus(1, AD_ES, 32'h7);
      chk(err, 1);
      for (int i = 0; i < 12; i++) begin
         bus(1, AD_CS, i);
         bus(0, AD_CS, 0);
         chk(rd, i);
      end
      $display("test registers done");
      for (int i = 0; i < 8; i++) begin
         d = 8'($random(seed));
         so = 1'($random(seed));
         bus(1, AD_OM, 0);
         bus(1, AD_CS, cs_t[i%3]);
         bus(1, AD_OM, {3'b101, 2'(i), 1'b1, so, 1'b0});
         frame(d, 2'(i), i[2], so, cyc_t[i%3], 1);
         bus(0, AD_ES, 0);
         chk(rd, exp_es(2'(i), i[2], so, 0));
         bus(0, AD_RB, 0);
         chk(rd, d);
         bus(0, AD_ES, 0);
         chk(rd, 0);
      end
      $display("test frames done");
      bus(1, AD_OM, 0);
      bus(1, AD_CS, 0);
      bus(1, AD_OM, 32'hBC);
      frame(8'h5A, 2'h3, 0, 1, 16, 1);
      frame(8'hC3, 2'h3, 1, 1, 16, 1);
      bus(0, AD_ES, 0);
      chk(rd, exp_es(2'h3, 1, 1, 1));
      bus(0, AD_RB, 0);
      chk(rd, 32'h5A);
      frame(8'h0F, 2'h3, 0, 0, 16, 1);
      bus(1, AD_OM, 32'h84);
      bus(0, AD_ES, 0);
      chk(rd, 0);
      frame(8'h33, 2'h3, 0, 1, 16, 0);
      $display("test overrun and disable done");
      // mid-run reset with a non-zero clock select in place
      bus(1, AD_CS, 5);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      bus(0, AD_CS, 0);
      chk(rd, 32'h0);
      bus(0, AD_OM, 0);
      chk(rd, 32'h0);
      $display("test mid-run reset done");
      close_out();
   end
endmodule
`default_nettype wire
